//--- qcp_pkg.sv
// Constants and types of the quadrature counter and synchronized PWM timer.
package qcp_pkg;

  // ==========================================================================
  // Geometry
  // ==========================================================================
  localparam int unsigned NCH   = 4;
  localparam int unsigned AW    = 12;
  localparam int unsigned PRE_W = 14;

  // ==========================================================================
  // Register map: channel n (0..3) occupies a window at n * CH_STRIDE
  // ==========================================================================
  localparam logic [AW-1:0] CH_STRIDE = 12'h020;
  localparam logic [4:0]    OFF_CTRL  = 5'h00;
  localparam logic [4:0]    OFF_IER   = 5'h04;
  localparam logic [4:0]    OFF_STAT  = 5'h08;
  localparam logic [4:0]    OFF_CNT   = 5'h0c;
  localparam logic [4:0]    OFF_CMPA  = 5'h10;
  localparam logic [4:0]    OFF_CMPB  = 5'h14;
  localparam logic [AW-1:0] ADDR_MODE = 12'h080;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned PSC_LSB   = 0;
  localparam int unsigned EDGE_LSB  = 3;
  localparam int unsigned CLR_LSB   = 5;
  localparam int unsigned PHASE_BIT = 7;
  localparam int unsigned SUB_LSB   = 8;
  localparam int unsigned CTRL_W    = 10;
  localparam int unsigned IE_CMPA   = 0;
  localparam int unsigned IE_CMPB   = 1;
  localparam int unsigned IE_OVF    = 4;
  localparam int unsigned IE_UNF    = 5;
  localparam int unsigned FLAG_W    = 6;
  localparam int unsigned ST_DIR    = 7;
  localparam int unsigned MODE_RUN  = 0;
  localparam int unsigned MODE_RSYN = 1;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
  localparam logic [FLAG_W-1:0] IER_RST  = 6'h00;
  localparam logic [FLAG_W-1:0] FLAG_RST = 6'h00;
  localparam logic [31:0]       CMP_RST  = 32'hffff_ffff;
  localparam logic [1:0]        MODE_RST = 2'h0;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {CLR_NONE, CLR_CMPA, CLR_CMPB, CLR_SPARE} qcp_clr_e;
  typedef enum logic [1:0] {PH_MODE1, PH_MODE2, PH_MODE3, PH_MODE4} qcp_sub_e;

  typedef struct packed {
    logic up;
    logic dn;
  } qcp_step_s;

  typedef struct packed {
    logic pair1_pos;
    logic pair1_neg;
    logic pair2_pos;
    logic pair2_neg;
    logic pair3_pos;
    logic pair3_neg;
  } qcp_pwm_s;

endpackage : qcp_pkg

//--- qcp_timer.sv
// Four channel timer with quadrature counting and synchronized PWM, on APB.
//
// Overview of operation
// - Quadrature counting exists only on channels one and two.
// - Quadrature mode counts encoder phases, ignoring prescaler and edge fields.
// - Clear select, compare registers, flags and interrupts still work then.
// - Up count overflow raises the overflow interrupt when its enable is one.
// - Down count underflow raises the underflow interrupt when enabled.
// - Status register shows the current count direction.
// - Channel one uses inputs one/two, channel two inputs three/four.
// - Four selectable quadrature sub-modes with distinct count conditions.
// - Sub-mode 1 counts on every edge of both phases.
// - Sub-mode 2 counts on falling A only: up if B high, else down.
// - Sub-mode 3: up on A fall with B high, down on B fall with A high.
// - Sub-mode 4 counts only on B edges, ignoring A edges.
// - Synchronized PWM joins channels three and four into three phases.
// - Six pins form three pairs, negative pin inverted from positive.
// - Channel three A sets period; three B, four A, four B set points.
// - Both counters count up and clear together on channel three A match.
// - Each PWM output toggles on its match and on every clear.
`timescale 1ns/1ps

module qcp_timer #(
  parameter int unsigned CNT_W = 16
) (
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [qcp_pkg::AW-1:0]     paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       ext_clock_in_one,
  input  wire logic                       ext_clock_in_two,
  input  wire logic                       ext_clock_in_three,
  input  wire logic                       ext_clock_in_four,
  output logic      [1:0]                 overflow_interrupt,
  output logic      [1:0]                 underflow_interrupt,
  output logic      [qcp_pkg::NCH-1:0]    compare_interrupt,
  output qcp_pkg::qcp_pwm_s               pwm_out
);
  import qcp_pkg::*;

  if (CNT_W < 2 || CNT_W > 32)
  begin : g_bad_width
    $error("CNT_W must lie between 2 and 32");
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [NCH-1:0] qcp_sel(input logic [AW-1:0] a,
                                             input logic [4:0]    off);
    logic [NCH-1:0] s;
    s = '0;
    for (int c = 0; c < NCH; c++)
      s[c] = (a == AW'(c * 32) + AW'(off));
    return s;
  endfunction : qcp_sel

  function automatic logic qcp_tick(input logic [PRE_W-1:0] pre,
                                    input logic [2:0]       psc);
    logic [PRE_W-1:0] m;
    m = PRE_W'((32'h1 << (2 * psc)) - 32'h1);
    return (pre & m) == '0;
  endfunction : qcp_tick

  // Inputs are {a_now, b_now, a_before, b_before}.
  function automatic qcp_step_s qcp_decode(input qcp_sub_e  sub,
                                           input logic [3:0] ph);
    logic a, b, ar, af, br, bf;
    qcp_step_s s;
    a  = ph[3];
    b  = ph[2];
    ar = a & ~ph[1];
    af = ~a & ph[1];
    br = b & ~ph[0];
    bf = ~b & ph[0];
    unique case (sub)
      PH_MODE1: s = '{up: (br & a) | (bf & ~a) | (ar & ~b) | (af & b),
                      dn: (br & ~a) | (bf & a) | (ar & b) | (af & ~b)};
      PH_MODE2: s = '{up: af & b, dn: af & ~b};
      PH_MODE3: s = '{up: af & b, dn: bf & a};
      PH_MODE4: s = '{up: (br & a) | (bf & ~a), dn: (br & ~a) | (bf & a)};
    endcase
    return s;
  endfunction : qcp_decode

  // ==========================================================================
  // State
  // ==========================================================================
  logic [CTRL_W-1:0] ctrl_r [NCH], ctrl_nxt [NCH];
  logic [FLAG_W-1:0] ier_r  [NCH], ier_nxt  [NCH];
  logic [FLAG_W-1:0] flag_r [NCH], flag_nxt [NCH];
  logic [CNT_W-1:0]  cnt_r  [NCH], cnt_nxt  [NCH];
  logic [CNT_W-1:0]  cmpa_r [NCH], cmpa_nxt [NCH];
  logic [CNT_W-1:0]  cmpb_r [NCH], cmpb_nxt [NCH];
  logic [NCH-1:0]    dir_r, dir_nxt;
  logic [1:0]        mode_r, mode_nxt;
  logic [PRE_W-1:0]  pre_r;
  logic [3:0]        s1_r, s2_r, prv_r;
  qcp_pwm_s          pwm_r, pwm_nxt;
  logic [31:0]       rdata_r, rdata_nxt;

  logic              run, rsync, rs_run, rs_clr, wr, mapped;
  logic [NCH-1:0]    phase_on, tick, mta, mtb, clr;
  qcp_step_s         step [NCH];

  assign run    = mode_r[MODE_RUN];
  assign rsync  = mode_r[MODE_RSYN];
  assign rs_run = run & rsync;
  assign rs_clr = rs_run & mta[2];
  assign wr     = psel & penable & pwrite;

  // ==========================================================================
  // Encoder pins: two-stage synchronizer, then an edge history stage
  // ==========================================================================
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_r  <= 4'h0;
      s2_r  <= 4'h0;
      prv_r <= 4'h0;
      pre_r <= '0;
    end
    else
    begin
      s1_r  <= {ext_clock_in_four, ext_clock_in_three,
                ext_clock_in_two, ext_clock_in_one};
      s2_r  <= s1_r;
      prv_r <= s2_r;
      pre_r <= pre_r + 1'b1;
    end
  end

  // ==========================================================================
  // Per channel count events and compare matches
  // ==========================================================================
  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    assign mta[i] = cnt_r[i] == cmpa_r[i];
    assign mtb[i] = cnt_r[i] == cmpb_r[i];
    // In synchronized mode channel four borrows channel three's prescaler so both stay in step.
    assign tick[i] = qcp_tick(pre_r,
                     ctrl_r[(i == 3 && rsync) ? 2 : i][PSC_LSB +: 3]);
    if (i < 2)
    begin : g_phase
      assign phase_on[i] = ctrl_r[i][PHASE_BIT];
      assign step[i] = phase_on[i]
        ? qcp_decode(qcp_sub_e'(ctrl_r[i][SUB_LSB +: 2]),
                     {s2_r[2*i], s2_r[2*i+1], prv_r[2*i], prv_r[2*i+1]})
        : '{up: tick[i], dn: 1'b0};
      assign clr[i] =
        (qcp_clr_e'(ctrl_r[i][CLR_LSB +: 2]) == CLR_CMPA && mta[i]) ||
        (qcp_clr_e'(ctrl_r[i][CLR_LSB +: 2]) == CLR_CMPB && mtb[i]);
    end
    else
    begin : g_plain
      assign phase_on[i] = 1'b0;
      assign step[i] = '{up: tick[i], dn: 1'b0};
      assign clr[i] = rsync ? rs_clr :
        (qcp_clr_e'(ctrl_r[i][CLR_LSB +: 2]) == CLR_CMPA && mta[i]) ||
        (qcp_clr_e'(ctrl_r[i][CLR_LSB +: 2]) == CLR_CMPB && mtb[i]);
    end
  end

  // ==========================================================================
  // Counters, flags and register writes
  // ==========================================================================
  always_comb
  begin
    logic up, dn;
    up       = 1'b0;
    dn       = 1'b0;
    ctrl_nxt = ctrl_r;
    ier_nxt  = ier_r;
    flag_nxt = flag_r;
    cnt_nxt  = cnt_r;
    cmpa_nxt = cmpa_r;
    cmpb_nxt = cmpb_r;
    dir_nxt  = dir_r;
    mode_nxt = mode_r;
    for (int i = 0; i < NCH; i++)
    begin
      up = run & step[i].up;
      dn = run & step[i].dn;
      if (run && clr[i])
        cnt_nxt[i] = '0;
      else if (up)
        cnt_nxt[i] = cnt_r[i] + 1'b1;
      else if (dn)
        cnt_nxt[i] = cnt_r[i] - 1'b1;
      if (up)
        dir_nxt[i] = 1'b1;
      else if (dn)
        dir_nxt[i] = 1'b0;
      // Set wins over a write-one clear in the same cycle.
      if (wr && qcp_sel(paddr, OFF_STAT)[i])
        flag_nxt[i] = flag_r[i] & ~pwdata[FLAG_W-1:0];
      flag_nxt[i][IE_CMPA] = flag_nxt[i][IE_CMPA] | (run & mta[i]);
      flag_nxt[i][IE_CMPB] = flag_nxt[i][IE_CMPB] | (run & mtb[i]);
      flag_nxt[i][IE_OVF]  = flag_nxt[i][IE_OVF] |
        (up & ~clr[i] & (cnt_r[i] == {CNT_W{1'b1}}));
      flag_nxt[i][IE_UNF]  = flag_nxt[i][IE_UNF] |
        (dn & ~clr[i] & (cnt_r[i] == '0));
      if (wr && qcp_sel(paddr, OFF_CTRL)[i])
        ctrl_nxt[i] = pwdata[CTRL_W-1:0];
      if (wr && qcp_sel(paddr, OFF_IER)[i])
        ier_nxt[i] = pwdata[FLAG_W-1:0];
      if (wr && qcp_sel(paddr, OFF_CNT)[i])
        cnt_nxt[i] = pwdata[CNT_W-1:0];
      if (wr && qcp_sel(paddr, OFF_CMPA)[i])
        cmpa_nxt[i] = pwdata[CNT_W-1:0];
      if (wr && qcp_sel(paddr, OFF_CMPB)[i])
        cmpb_nxt[i] = pwdata[CNT_W-1:0];
    end
    if (wr && paddr == ADDR_MODE)
      mode_nxt = pwdata[1:0];
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        ctrl_r[i] <= CTRL_RST;
        ier_r[i]  <= IER_RST;
        flag_r[i] <= FLAG_RST;
        cnt_r[i]  <= '0;
        cmpa_r[i] <= CMP_RST[CNT_W-1:0];
        cmpb_r[i] <= CMP_RST[CNT_W-1:0];
      end
      dir_r  <= '0;
      mode_r <= MODE_RST;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      ier_r  <= ier_nxt;
      flag_r <= flag_nxt;
      cnt_r  <= cnt_nxt;
      cmpa_r <= cmpa_nxt;
      cmpb_r <= cmpb_nxt;
      dir_r  <= dir_nxt;
      mode_r <= mode_nxt;
    end
  end

  for (genvar i = 0; i < NCH; i++)
  begin : g_irq
    assign compare_interrupt[i] =
      (flag_r[i][IE_CMPA] & ier_r[i][IE_CMPA]) |
      (flag_r[i][IE_CMPB] & ier_r[i][IE_CMPB]);
    if (i < 2)
    begin : g_ovf
      assign overflow_interrupt[i]  =
        flag_r[i][IE_OVF] & ier_r[i][IE_OVF];
      assign underflow_interrupt[i] =
        flag_r[i][IE_UNF] & ier_r[i][IE_UNF];
    end
  end

  // ==========================================================================
  // Synchronized PWM: match and common clear both toggle each pair
  // ==========================================================================
  // Counters three and four must hold zero when the run bit is set.
  always_comb
  begin
    logic t1, t2, t3;
    t1 = rs_run & (mtb[2] ^ mta[2]);
    t2 = rs_run & (mta[3] ^ mta[2]);
    t3 = rs_run & (mtb[3] ^ mta[2]);
    pwm_nxt = '0;
    if (rsync)
    begin
      pwm_nxt.pair1_pos = pwm_r.pair1_pos ^ t1;
      pwm_nxt.pair2_pos = pwm_r.pair2_pos ^ t2;
      pwm_nxt.pair3_pos = pwm_r.pair3_pos ^ t3;
      pwm_nxt.pair1_neg = ~pwm_nxt.pair1_pos;
      pwm_nxt.pair2_neg = ~pwm_nxt.pair2_pos;
      pwm_nxt.pair3_neg = ~pwm_nxt.pair3_pos;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pwm_r <= '0;
    else
      pwm_r <= pwm_nxt;
  end

  assign pwm_out = pwm_r;

  // ==========================================================================
  // APB slave: data is fetched in setup, answered in the first access cycle
  // ==========================================================================
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (psel && !penable && !pwrite)
    begin
      rdata_nxt = 32'h0;
      for (int i = 0; i < NCH; i++)
      begin
        if (qcp_sel(paddr, OFF_CTRL)[i]) rdata_nxt = 32'(ctrl_r[i]);
        if (qcp_sel(paddr, OFF_IER)[i])  rdata_nxt = 32'(ier_r[i]);
        if (qcp_sel(paddr, OFF_STAT)[i])
          rdata_nxt = 32'({dir_r[i], 1'b0, flag_r[i]});
        if (qcp_sel(paddr, OFF_CNT)[i])  rdata_nxt = 32'(cnt_r[i]);
        if (qcp_sel(paddr, OFF_CMPA)[i]) rdata_nxt = 32'(cmpa_r[i]);
        if (qcp_sel(paddr, OFF_CMPB)[i]) rdata_nxt = 32'(cmpb_r[i]);
      end
      if (paddr == ADDR_MODE)
        rdata_nxt = 32'(mode_r);
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata_r <= 32'h0;
    else
      rdata_r <= rdata_nxt;
  end

  assign mapped  = (paddr == ADDR_MODE) ||
                   (|{qcp_sel(paddr, OFF_CTRL), qcp_sel(paddr, OFF_IER),
                      qcp_sel(paddr, OFF_STAT), qcp_sel(paddr, OFF_CNT),
                      qcp_sel(paddr, OFF_CMPA), qcp_sel(paddr, OFF_CMPB)});
  assign prdata  = rdata_r;
  assign pready  = psel & penable;
  assign pslverr = psel & penable & ~mapped;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_no_phase_ch34: assert property (!phase_on[2] && !phase_on[3])
    else $error("phase counting on channel three or four");
  a_phase_holds: assert property (phase_on[0] && run && !step[0].up &&
    !step[0].dn && !clr[0] && !wr |=> $stable(cnt_r[0]))
    else $error("phase counter moved without an encoder event");
  a_cmp_flag: assert property (phase_on[0] && run && mta[0]
    |=> flag_r[0][IE_CMPA])
    else $error("compare flag missing in phase mode");
  a_ovf_raise: assert property (run && step[0].up && !clr[0] && !wr &&
    cnt_r[0] == {CNT_W{1'b1}} && ier_r[0][IE_OVF]
    |=> cnt_r[0] == '0 ##0 overflow_interrupt[0])
    else $error("overflow not raised");
  a_unf_raise: assert property (run && step[1].dn && !clr[1] && !wr &&
    cnt_r[1] == '0 && ier_r[1][IE_UNF]
    |=> underflow_interrupt[1] && cnt_r[1] == {CNT_W{1'b1}})
    else $error("underflow not raised");
  a_dir_down: assert property (run && step[1].dn |=> !dir_r[1])
    else $error("direction flag not down");
  a_pin_map: assert property (s2_r[2] == $past(ext_clock_in_three, 2))
    else $error("channel two A phase not from input three");
  a_mode1_up: assert property (phase_on[0] && ctrl_r[0][SUB_LSB +: 2] == 2'h0
    && s2_r[1] && !prv_r[1] && s2_r[0] |-> step[0].up)
    else $error("mode 1 missed an up count");
  a_mode2_a_only: assert property (phase_on[0] &&
    ctrl_r[0][SUB_LSB +: 2] == 2'h1 && s2_r[0] == prv_r[0]
    |-> !step[0].up && !step[0].dn)
    else $error("mode 2 counted without an A edge");
  a_mode3_down: assert property (phase_on[0] &&
    ctrl_r[0][SUB_LSB +: 2] == 2'h2 && step[0].dn
    |-> prv_r[1] && !s2_r[1] && s2_r[0])
    else $error("mode 3 down count without B fall and A high");
  a_mode4_b_only: assert property (phase_on[0] &&
    ctrl_r[0][SUB_LSB +: 2] == 2'h3 && s2_r[1] == prv_r[1]
    |-> !step[0].up && !step[0].dn)
    else $error("mode 4 counted without a B edge");
  a_rs_clear: assert property (rs_clr && !wr
    |=> cnt_r[2] == '0 && cnt_r[3] == '0)
    else $error("counters three and four not cleared together");
  a_pwm_toggle: assert property (rs_run && mtb[2] && !mta[2] && !wr
    |=> pwm_out.pair1_pos != $past(pwm_out.pair1_pos))
    else $error("pair one did not toggle on match");
  a_pwm_inverse: assert property ($past(rsync) |-> pwm_out.pair2_neg
    == !pwm_out.pair2_pos && pwm_out.pair3_neg == !pwm_out.pair3_pos)
    else $error("negative pin not inverse of positive");

  c_phase_ovf: cover property (phase_on[0] && flag_r[0][IE_OVF]);
  c_phase_unf: cover property (phase_on[1] && flag_r[1][IE_UNF]);
  c_rs_clear: cover property (rs_clr ##1 rs_run [*3] ##1 rs_clr);
  c_pwm_pair3: cover property (rs_run && mtb[3]);

endmodule : qcp_timer

//--- qcp_encoder.sv
// Two-phase encoder model that drives one channel's phase inputs.
`timescale 1ns/1ps

module qcp_encoder (
  input  wire logic clk,
  output logic      pha,
  output logic      phb
);
  // Phase pairs {a, b}: forward leads with A, reverse leads with B.
  localparam logic [1:0] FWD [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
  localparam logic [1:0] REV [4] = '{2'b01, 2'b11, 2'b10, 2'b00};

  initial
  begin
    pha = 1'b0;
    phb = 1'b0;
  end

  // A gap under three clocks would let a read miss the last edge behind the pin synchroniser.
  task automatic step_to(input logic a, input logic b, input int gap);
    @(posedge clk);
    pha <= a;
    phb <= b;
    repeat (gap) @(posedge clk);
  endtask : step_to

  task automatic move(input logic fwd, input int gap);
    logic [1:0] ab;
    for (int k = 0; k < 4; k++)
    begin
      ab = fwd ? FWD[k] : REV[k];
      step_to(ab[1], ab[0], gap);
    end
  endtask : move
endmodule : qcp_encoder

//--- qcp_timer_bench.sv
// Self-checking bench for the quadrature counter and synchronized PWM.
`timescale 1ns/1ps

module qcp_timer_bench;
  import qcp_pkg::*;
  logic           clk = 1'b0;
  logic           reset_n, psel, penable, pwrite, pready, pslverr, e;
  logic [AW-1:0]  paddr;
  logic [31:0]    pwdata, prdata, q;
  logic           a1, b1, a2, b2;
  logic [1:0]     ovf_irq, unf_irq;
  logic [NCH-1:0] cmp_irq;
  qcp_pwm_s       pwm;
  int             err_count = 0;
  int             samples_checked = 0;
  int             stp [4] = '{4, 1, 1, 2};
  int             tp [3] = '{2, 4, 6};

  always #12.5 clk = ~clk;

  qcp_timer uut (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clock_in_one(a1), .ext_clock_in_two(b1),
    .ext_clock_in_three(a2), .ext_clock_in_four(b2),
    .overflow_interrupt(ovf_irq), .underflow_interrupt(unf_irq),
    .compare_interrupt(cmp_irq), .pwm_out(pwm));
  qcp_encoder enc1 (.clk(clk), .pha(a1), .phb(b1));
  qcp_encoder enc2 (.clk(clk), .pha(a2), .phb(b2));

  // ==========================================================================
  // Checking and bus tasks
  // ==========================================================================
  task automatic stop_test;
    $display("Mismatches %0d, comparisons %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic [AW-1:0] a, input logic w,
                      input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clk);
    end
    if (n >= 50)
      err_count++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer

  function automatic logic [AW-1:0] ra(input int c, input logic [4:0] off);
    return CH_STRIDE * AW'(c) + AW'(off);
  endfunction : ra

  task automatic wr(input int c, input logic [4:0] off, input logic [31:0] d);
    xfer(ra(c, off), 1'b1, d);
  endtask : wr

  task automatic rd(input int c, input logic [4:0] off, input logic [31:0] x);
    xfer(ra(c, off), 1'b0, 32'h0);
    chk(q, x);
  endtask : rd

  // Prescaler set to its slowest on purpose: it must not matter here.
  function automatic logic [31:0] qctl(input int s);
    return 32'((1 << PHASE_BIT) | (s << SUB_LSB) | 7);
  endfunction : qctl

  // One full output period is 10 ticks; toggles split it at the point.
  task automatic pwm_gap(input int i, input int t);
    int c [3];
    logic [5:0] p;
    logic v;
    for (int k = 0; k < 3; k++)
    begin
      c[k] = 0;
      p = pwm;
      v = p[5-2*i];
      do
      begin
        @(posedge clk);
        #1;
        p = pwm;
        c[k]++;
      end while (p[5-2*i] === v && c[k] < 40);
      chk(32'(p[5-2*i] ^ p[4-2*i]), 32'h1);
    end
    chk(32'(c[1] + c[2]), 32'h0000000a);
    chk(32'(c[1] * c[2]), 32'((9 - t) * (t + 1)));
    @(posedge clk);
  endtask : pwm_gap

  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial
  begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(0, OFF_CTRL, 32'h0);
    rd(1, OFF_IER, 32'h0);
    xfer(12'h0fc, 1'b0, 32'h0);
    chk({31'h0, e}, 32'h1);
    // Phase mode first: a plain channel zero would count ticks once run.
    wr(0, OFF_CTRL, qctl(0));
    xfer(ADDR_MODE, 1'b1, 32'h1);
    for (int s = 0; s < 4; s++)
    begin
      wr(0, OFF_CTRL, qctl(s));
      enc1.move(1'b1, 3);
      rd(0, OFF_CNT, 32'(stp[s]));
      rd(0, OFF_STAT, 32'h80);
      enc1.move(1'b0, 6);
      rd(0, OFF_CNT, 32'h0);
      rd(0, OFF_STAT, 32'h0);
    end
    wr(1, OFF_CTRL, qctl(0));
    wr(1, OFF_CNT, 32'h0);
    enc2.move(1'b1, 3);
    rd(1, OFF_CNT, 32'h4);
    rd(0, OFF_CNT, 32'h0);
    wr(0, OFF_CTRL, qctl(0));
    wr(0, OFF_IER, 32'h20);
    enc1.step_to(1'b0, 1'b1, 3);
    rd(0, OFF_CNT, 32'h0000ffff);
    rd(0, OFF_STAT, 32'h23);
    chk({30'h0, unf_irq}, 32'h1);
    enc1.step_to(1'b0, 1'b0, 3);
    rd(0, OFF_CNT, 32'h0);
    rd(0, OFF_STAT, 32'hb3);
    chk({30'h0, ovf_irq}, 32'h0);
    wr(0, OFF_STAT, 32'h33);
    rd(0, OFF_STAT, 32'h80);
    chk({30'h0, unf_irq}, 32'h0);
    wr(0, OFF_CMPA, 32'h3);
    wr(0, OFF_IER, 32'h1);
    wr(0, OFF_CTRL, qctl(0) | (32'h1 << CLR_LSB));
    enc1.move(1'b1, 3);
    rd(0, OFF_CNT, 32'h1);
    rd(0, OFF_STAT, 32'h81);
    chk({28'h0, cmp_irq}, 32'h1);
    xfer(ADDR_MODE, 1'b1, 32'h0);
    wr(2, OFF_CNT, 32'h0);
    wr(3, OFF_CNT, 32'h0);
    wr(2, OFF_CMPA, 32'h9);
    wr(2, OFF_CMPB, 32'(tp[0]));
    wr(3, OFF_CMPA, 32'(tp[1]));
    wr(3, OFF_CMPB, 32'(tp[2]));
    wr(2, OFF_CTRL, 32'h0);
    xfer(ADDR_MODE, 1'b1, 32'h3);
    for (int i = 0; i < 3; i++)
      pwm_gap(i, tp[i]);
    xfer(ADDR_MODE, 1'b1, 32'h0);
    repeat (2) @(posedge clk);
    chk({26'h0, pwm}, 32'h0);
    stop_test();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    stop_test();
  end
endmodule : qcp_timer_bench
